// File: design/asr_defines.svh
// Purpose: Constants for the auto-sleep and rate control block.
// Assumes: 100 MHz core clock; registers are 8 bits wide.
// Notes: Timing counts are derived in the top module from these figures.
// Function
// - Inactivity expiry switches to sleep rate
// - Timeout steps 320 ms, 640 ms at slowest
// - Enabled detection events restart the inactivity timer
// - Wake only on enabled and selected sources
// - Enabled functions keep running at sleep rate
// - Sleep-transition and data-ready never wake
// - Auto-sleep off means standby or wake only
// - Interrupt on every sleep/wake transition
// - Sleep-rate field picks 50/12.5/6.25/1.56 Hz
// - Sleep rate overrides all functional rates
// - Data-rate field picks 800 Hz to 1.56 Hz
// - Active bit selects standby or active, resets 0
// - Low-noise mode limits range to 4g
// - Fast read skips low data bytes
// - Self-test bit shifts axis outputs
// - Soft reset reloads defaults and serial logic
// - Soft-reset bit self-clears, reads zero
// - Wake and sleep oversampling fields, default 00
// - Auto-sleep enable gates sleep entry, default 0
// - Wake-select bits bypass unselected wake sources
`ifndef ASR_DEFINES_SVH
`define ASR_DEFINES_SVH

`define ASR_ADDR_TIMEOUT 8'h29
`define ASR_ADDR_RATE 8'h2A
`define ASR_ADDR_POWER 8'h2B
`define ASR_ADDR_X_MSB 8'h01
`define ASR_ADDR_Y_MSB 8'h03
`define ASR_ADDR_Z_MSB 8'h05
`define ASR_ADDR_Z_LSB 8'h06
`define ASR_PTR_STEP 8'h01
`define ASR_PTR_SKIP 8'h02

`define ASR_RC_ACTIVE 0
`define ASR_RC_FREAD 1
`define ASR_RC_LOW_NOISE_SEL 2
`define ASR_RC_DR_LO 3
`define ASR_RC_DR_HI 5
`define ASR_RC_SR_LO 6
`define ASR_RC_SR_HI 7

`define ASR_PC_WOS_LO 0
`define ASR_PC_WOS_HI 1
`define ASR_PC_AUTO_SLEEP_EN 2
`define ASR_PC_SOS_LO 3
`define ASR_PC_SOS_HI 4
`define ASR_PC_RST 6
`define ASR_PC_ST 7
`define ASR_PC_STORE_MASK 8'h9F

`define ASR_RESET_BYTE 8'h00
`define ASR_ZERO_BYTE 8'h00
`define ASR_ONE_BYTE 8'h01
`define ASR_DR_SLOWEST 3'h7
`define ASR_SLEEP_RATE_MSB 1'h1

`define ASR_CLK_KHZ 100000
`define ASR_STEP_FAST_MS 320
`define ASR_STEP_SLOW_MS 640
`define ASR_PRESC_W 26
`define ASR_PRESC_ZERO 26'h0000000
`define ASR_PRESC_ONE 26'h0000001

`endif

// File: design/asr_pkg.sv
// Purpose: Types shared by the auto-sleep and rate control block.
// Assumes: asr_defines.svh supplies widths.
// Notes: All module state is one packed struct.
`include "asr_defines.svh"

package asr_pkg;

  typedef enum logic [1:0] {
    ASR_STANDBY = 2'b00,
    ASR_WAKE = 2'b01,
    ASR_SLEEP = 2'b10
  } asr_mode_e;

  typedef struct packed {
    asr_mode_e mode;
    logic [7:0] timeout;
    logic [7:0] rate_ctl;
    logic [7:0] power_ctl;
    logic [7:0] inact_cnt;
    logic [`ASR_PRESC_W-1:0] presc;
    logic [7:0] rdata;
    logic rd_valid;
    logic [7:0] burst_ptr;
    logic sleep_irq;
    logic serial_rst;
  } asr_state_s;

endpackage

// File: design/asr_top.sv
// Purpose: Power-mode state, sample-rate selection and inactivity timer.
// Assumes: Register port comes from the serial slave; events are pulses.
// Notes: State freezes while ce is low.
`timescale 1ns/1ns
`include "asr_defines.svh"

module asr_top
  import asr_pkg::*;
#(
  parameter int STEP_FAST_CYC = `ASR_STEP_FAST_MS * `ASR_CLK_KHZ,
  parameter int STEP_SLOW_CYC = `ASR_STEP_SLOW_MS * `ASR_CLK_KHZ
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // Register port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  // Burst address pointer
  input wire logic ptr_load,
  input wire logic ptr_step,
  output logic [7:0] burst_addr,
  // Detection events
  input wire logic transient_event,
  input wire logic orientation_event,
  input wire logic pulse_event,
  input wire logic freefall_motion_event,
  // Function enables and wake selects
  input wire logic [3:0] func_int_en,
  input wire logic [3:0] wake_sel,
  input wire logic sleep_int_en,
  // Mode and rate outputs
  output logic mode_active,
  output logic mode_sleep,
  output logic [2:0] output_sample_rate,
  output logic [1:0] oversample_sel,
  output logic low_noise_sel,
  output logic fast_read,
  output logic self_test_en,
  output logic functions_run,
  // Event and reset outputs
  output logic sleep_transition_event,
  output logic serial_if_reset
);

  asr_state_s st_reg;
  asr_state_s st_next;

  logic [3:0] evt_vec;
  logic [3:0] evt_enabled;
  logic restart_evt;
  logic wake_evt;
  logic auto_sleep_en;
  logic [2:0] data_rate_sel;
  logic [1:0] sleep_rate_sel;
  logic [1:0] wake_oversample_sel;
  logic [1:0] sleep_oversample_sel;
  logic [`ASR_PRESC_W-1:0] step_last;
  logic step_done;
  logic wr_timeout;
  logic wr_rate;
  logic wr_power;
  logic soft_reset;
  logic [7:0] rate_wr_val;
  logic [7:0] power_wr_val;
  logic [7:0] ptr_inc;

  // Field views of the control registers
  assign data_rate_sel = st_reg.rate_ctl[`ASR_RC_DR_HI:`ASR_RC_DR_LO];
  assign sleep_rate_sel = st_reg.rate_ctl[`ASR_RC_SR_HI:`ASR_RC_SR_LO];
  assign auto_sleep_en = st_reg.power_ctl[`ASR_PC_AUTO_SLEEP_EN];
  assign wake_oversample_sel = st_reg.power_ctl[`ASR_PC_WOS_HI:`ASR_PC_WOS_LO];
  assign sleep_oversample_sel = st_reg.power_ctl[`ASR_PC_SOS_HI:`ASR_PC_SOS_LO];

  // Only the four detection functions count as activity
  assign evt_vec = {transient_event, orientation_event, pulse_event, freefall_motion_event};
  assign evt_enabled = evt_vec & func_int_en;
  assign restart_evt = |evt_enabled;
  // Sleep-transition and data-ready are not inputs here, so they cannot wake
  assign wake_evt = |(evt_enabled & wake_sel);

  // Step length follows the wake data rate
  always_comb begin
    if (data_rate_sel == `ASR_DR_SLOWEST) begin
      step_last = `ASR_PRESC_W'(STEP_SLOW_CYC - 1);
    end else begin
      step_last = `ASR_PRESC_W'(STEP_FAST_CYC - 1);
    end
  end
  assign step_done = (st_reg.presc == step_last);

  // Register write decode
  assign wr_timeout = reg_wr_en && (reg_addr == `ASR_ADDR_TIMEOUT);
  assign wr_rate = reg_wr_en && (reg_addr == `ASR_ADDR_RATE);
  assign wr_power = reg_wr_en && (reg_addr == `ASR_ADDR_POWER);
  assign soft_reset = wr_power && reg_wdata[`ASR_PC_RST];

  // Fields other than active are taken as written; host keeps to standby
  assign rate_wr_val = wr_rate ? reg_wdata : st_reg.rate_ctl;
  // Soft-reset bit is never stored, so it reads back zero
  assign power_wr_val = wr_power ? (reg_wdata & `ASR_PC_STORE_MASK) : st_reg.power_ctl;

  // Fast read jumps by two from each axis high byte, skipping its low byte
  always_comb begin
    ptr_inc = `ASR_PTR_STEP;
    if (st_reg.rate_ctl[`ASR_RC_FREAD]) begin
      if (st_reg.burst_ptr == `ASR_ADDR_X_MSB ||
          st_reg.burst_ptr == `ASR_ADDR_Y_MSB ||
          st_reg.burst_ptr == `ASR_ADDR_Z_MSB) begin
        ptr_inc = `ASR_PTR_SKIP;
      end
    end
  end

  always_comb begin
    st_next = st_reg;
    st_next.sleep_irq = 1'b0;
    st_next.serial_rst = 1'b0;
    st_next.rd_valid = 1'b0;

    // Register reads
    if (reg_rd_en) begin
      st_next.rd_valid = 1'b1;
      case (reg_addr)
        `ASR_ADDR_TIMEOUT: begin
          st_next.rdata = st_reg.timeout;
        end
        `ASR_ADDR_RATE: begin
          st_next.rdata = st_reg.rate_ctl;
        end
        `ASR_ADDR_POWER: begin
          st_next.rdata = st_reg.power_ctl;
        end
        default: begin
          st_next.rdata = `ASR_ZERO_BYTE;
        end
      endcase
    end

    // Burst pointer
    if (ptr_load) begin
      st_next.burst_ptr = reg_addr;
    end else if (ptr_step) begin
      st_next.burst_ptr = st_reg.burst_ptr + ptr_inc;
    end

    // Register writes
    if (wr_timeout) begin
      st_next.timeout = reg_wdata;
    end
    st_next.rate_ctl = rate_wr_val;
    st_next.power_ctl = power_wr_val;

    // Prescaler runs only while awake and timing inactivity
    if (step_done) begin
      st_next.presc = `ASR_PRESC_ZERO;
    end else begin
      st_next.presc = st_reg.presc + `ASR_PRESC_ONE;
    end

    case (st_reg.mode)
      ASR_STANDBY: begin
        st_next.presc = `ASR_PRESC_ZERO;
        st_next.inact_cnt = st_reg.timeout;
        if (rate_wr_val[`ASR_RC_ACTIVE]) begin
          st_next.mode = ASR_WAKE;
          st_next.inact_cnt = wr_timeout ? reg_wdata : st_reg.timeout;
        end
      end
      ASR_WAKE: begin
        if (!rate_wr_val[`ASR_RC_ACTIVE]) begin
          st_next.mode = ASR_STANDBY;
          st_next.presc = `ASR_PRESC_ZERO;
        end else if (!auto_sleep_en) begin
          // Timer held, sleep never entered
          st_next.presc = `ASR_PRESC_ZERO;
          st_next.inact_cnt = st_reg.timeout;
        end else if (restart_evt) begin
          st_next.presc = `ASR_PRESC_ZERO;
          st_next.inact_cnt = st_reg.timeout;
        end else if (step_done) begin
          // Zero or one left means this boundary ends the wait
          if (st_reg.inact_cnt <= `ASR_ONE_BYTE) begin
            st_next.mode = ASR_SLEEP;
            st_next.sleep_irq = sleep_int_en;
          end else begin
            st_next.inact_cnt = st_reg.inact_cnt - `ASR_ONE_BYTE;
          end
        end
      end
      ASR_SLEEP: begin
        st_next.presc = `ASR_PRESC_ZERO;
        if (!rate_wr_val[`ASR_RC_ACTIVE]) begin
          st_next.mode = ASR_STANDBY;
        end else if (wake_evt || !auto_sleep_en) begin
          // Back to the data rate with a fresh timeout
          st_next.mode = ASR_WAKE;
          st_next.inact_cnt = st_reg.timeout;
          st_next.sleep_irq = sleep_int_en;
        end
      end
      default: begin
        st_next.mode = ASR_STANDBY;
      end
    endcase

    // Soft reset overrides every mode, register and timer update in any mode
    if (soft_reset) begin
      st_next.mode = ASR_STANDBY;
      st_next.timeout = `ASR_RESET_BYTE;
      st_next.rate_ctl = `ASR_RESET_BYTE;
      st_next.power_ctl = `ASR_RESET_BYTE;
      st_next.inact_cnt = `ASR_RESET_BYTE;
      st_next.presc = `ASR_PRESC_ZERO;
      st_next.burst_ptr = `ASR_RESET_BYTE;
      st_next.sleep_irq = 1'b0;
      st_next.serial_rst = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_reg.mode <= ASR_STANDBY;
      st_reg.timeout <= `ASR_RESET_BYTE;
      st_reg.rate_ctl <= `ASR_RESET_BYTE;
      st_reg.power_ctl <= `ASR_RESET_BYTE;
      st_reg.inact_cnt <= `ASR_RESET_BYTE;
      st_reg.presc <= `ASR_PRESC_ZERO;
      st_reg.rdata <= `ASR_ZERO_BYTE;
      st_reg.rd_valid <= 1'b0;
      st_reg.burst_ptr <= `ASR_RESET_BYTE;
      st_reg.sleep_irq <= 1'b0;
      st_reg.serial_rst <= 1'b0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // Outputs
  assign reg_rdata = st_reg.rdata;
  assign reg_rd_valid = st_reg.rd_valid;
  assign burst_addr = st_reg.burst_ptr;
  assign mode_active = (st_reg.mode != ASR_STANDBY);
  assign mode_sleep = (st_reg.mode == ASR_SLEEP);

  // One rate drives the output and every detection function
  always_comb begin
    if (st_reg.mode == ASR_SLEEP) begin
      output_sample_rate = {`ASR_SLEEP_RATE_MSB, sleep_rate_sel};
      oversample_sel = sleep_oversample_sel;
    end else begin
      output_sample_rate = data_rate_sel;
      oversample_sel = wake_oversample_sel;
    end
  end

  // Functions stay enabled in sleep, only slower
  assign functions_run = mode_active;
  assign low_noise_sel = st_reg.rate_ctl[`ASR_RC_LOW_NOISE_SEL];
  assign fast_read = st_reg.rate_ctl[`ASR_RC_FREAD];
  assign self_test_en = st_reg.power_ctl[`ASR_PC_ST];
  assign sleep_transition_event = st_reg.sleep_irq;
  assign serial_if_reset = st_reg.serial_rst;

endmodule

// File: tb/asr_properties.sv
// Purpose: Port-level properties of the rate control block.
// Assumes: One clock domain, synchronous reset.
// Notes: Bound to every asr_top instance.
`timescale 1ns/1ns
module asr_properties (
  // Clock and control
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // Register port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_valid,
  // Events and selects
  input wire logic transient_event,
  input wire logic orientation_event,
  input wire logic pulse_event,
  input wire logic freefall_motion_event,
  input wire logic [3:0] func_int_en,
  input wire logic [3:0] wake_sel,
  input wire logic sleep_int_en,
  // Mode outputs
  input wire logic mode_active,
  input wire logic mode_sleep,
  input wire logic [2:0] output_sample_rate,
  input wire logic functions_run,
  input wire logic sleep_transition_event,
  input wire logic serial_if_reset
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [3:0] hits;
  assign hits = {transient_event, orientation_event, pulse_event, freefall_motion_event} & func_int_en & wake_sel;
  // Writes excluded: clearing auto-sleep also wakes
  sequence s_idle_sleep;
    ce && mode_sleep && !reg_wr_en;
  endsequence
  read_answer_a: assert property (ce && reg_rd_en |=> reg_rd_valid)
    else $error("read not answered");
  reset_bit_a: assert property (ce && reg_rd_en && reg_addr == 8'h2B |=> !reg_rdata[6])
    else $error("reset bit read as one");
  soft_reset_a: assert property (ce && reg_wr_en && reg_addr == 8'h2B && reg_wdata[6]
    |=> serial_if_reset && !mode_active && output_sample_rate == 3'h0) else $error("soft reset missed");
  sleep_rate_a: assert property (mode_sleep |-> output_sample_rate[2])
    else $error("sleep rate not used");
  sleep_irq_a: assert property ($rose(mode_sleep) && sleep_int_en |-> sleep_transition_event)
    else $error("no sleep entry pulse");
  sleep_entry_a: assert property ($rose(mode_sleep) |-> $past(mode_active))
    else $error("sleep entered from standby");
  wake_irq_a: assert property ($fell(mode_sleep) && mode_active && sleep_int_en |-> sleep_transition_event)
    else $error("no wake pulse");
  irq_cause_a: assert property (sleep_transition_event && $past(ce) |-> $changed(mode_sleep))
    else $error("transition pulse without mode change");
  wake_event_a: assert property (s_idle_sleep ##0 (hits != 4'h0) |=> !mode_sleep && mode_active)
    else $error("selected event did not wake");
  no_wake_a: assert property (s_idle_sleep ##0 (hits == 4'h0) |=> mode_sleep)
    else $error("woke without selected event");
  run_asleep_a: assert property (functions_run == mode_active && (mode_active || !mode_sleep))
    else $error("functions stopped");
endmodule

bind asr_top asr_properties u_props (.core_clk, .rst, .ce, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
  .reg_rdata, .reg_rd_valid, .transient_event, .orientation_event, .pulse_event, .freefall_motion_event,
  .func_int_en, .wake_sel, .sleep_int_en, .mode_active, .mode_sleep, .output_sample_rate, .functions_run,
  .sleep_transition_event, .serial_if_reset);

// File: tb/asr_host.sv
// Purpose: Host register master for the rate control block.
// Assumes: One request at a time, strobes one cycle wide.
// Notes: Idle address and data show the inverse of the last value.
`timescale 1ns/1ns
module asr_host (
  // Clock and answer
  input wire logic core_clk,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_valid,
  // Requests
  output logic reg_wr_en = 1'b0,
  output logic reg_rd_en = 1'b0,
  output logic [7:0] reg_addr = 8'h00,
  output logic [7:0] reg_wdata = 8'h00,
  output logic ptr_load = 1'b0,
  output logic ptr_step = 1'b0
);
  logic [7:0] rc_shadow = 8'h00;
  task automatic req(input logic [3:0] k, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1 {reg_wr_en, reg_rd_en, ptr_load, ptr_step} = k;
    reg_addr = a;
    reg_wdata = d;
    @(posedge core_clk);
    #1 {reg_wr_en, reg_rd_en, ptr_load, ptr_step} = 4'h0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req(4'h8, a, d);
    if (a == 8'h2B && d[6]) begin
      rc_shadow = 8'h00;
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [8:0] r);
    req(4'h4, a, 8'h00);
    r = {reg_rd_valid, reg_rdata};
  endtask
  // Drop to standby first, fields may only change there
  task automatic set_rate(input logic [7:0] d);
    wr(8'h2A, {rc_shadow[7:1], 1'b0});
    wr(8'h2A, d);
    rc_shadow = d;
  endtask
endmodule

// File: tb/tb.sv
// Purpose: Self-checking bench for the auto-sleep and rate control block.
// Assumes: Short step counts stand in for the real timeout steps.
// Notes: Seeded random fields with fixed corner cases.
`timescale 1ns/1ns
module tb;
  localparam int FAST = 4;
  localparam int SLOW = 8;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic sleep_int_en = 1'b0;
  logic [3:0] ev = 4'h0;
  logic [3:0] func_int_en = 4'h0;
  logic [3:0] wake_sel = 4'h0;
  logic reg_wr_en, reg_rd_en, ptr_load, ptr_step, reg_rd_valid, mode_active, mode_sleep, low_noise_sel;
  logic fast_read, self_test_en, functions_run, sleep_transition_event, serial_if_reset;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, burst_addr, rc, pc, tmo;
  logic [2:0] output_sample_rate;
  logic [1:0] oversample_sel;
  logic [8:0] r;
  int failures = 0;
  int tests_run = 0;
  int cyc = 0;
  int n, b;
  always #5 core_clk = ~core_clk;
  asr_top #(.STEP_FAST_CYC(FAST), .STEP_SLOW_CYC(SLOW)) u_dut (.core_clk, .rst, .ce, .reg_wr_en,
    .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .reg_rd_valid, .ptr_load, .ptr_step, .burst_addr,
    .transient_event(ev[3]), .orientation_event(ev[2]), .pulse_event(ev[1]), .freefall_motion_event(ev[0]),
    .func_int_en, .wake_sel, .sleep_int_en, .mode_active, .mode_sleep, .output_sample_rate, .oversample_sel,
    .low_noise_sel, .fast_read, .self_test_en, .functions_run, .sleep_transition_event, .serial_if_reset);
  asr_host u_host (.core_clk, .reg_rdata, .reg_rd_valid, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
    .ptr_load, .ptr_step);
  task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim;
    if (failures == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  function automatic int exp_delay(input logic [7:0] t, input logic [2:0] d);
    return ((t == 8'h00) ? 1 : int'(t)) * ((d == 3'h7) ? SLOW : FAST);
  endfunction
  task automatic wait_mode(input logic want, input int lim);
    n = 0;
    while (mode_sleep !== want && n < lim) begin
      @(posedge core_clk);
      #1 n++;
    end
  endtask
  task automatic pulse(input logic [3:0] v);
    @(posedge core_clk);
    #1 ev = v;
    @(posedge core_clk);
    #1 ev = 4'h0;
  endtask
  task automatic chk_defaults;
    for (int a = 8'h29; a <= 8'h2B; a++) begin
      u_host.rd(8'(a), r);
      chk("default", r, 9'h100);
    end
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    b = $urandom(32'h5A958DCD);
    repeat (5) @(posedge core_clk);
    #1 rst = 1'b0;
    chk_defaults();
    u_host.rd(8'h50, r);
    chk("unmapped", r, 9'h100);
    repeat (4) begin
      pc = 8'($urandom) & 8'hBF;
      tmo = 8'($urandom);
      u_host.wr(8'h2B, pc);
      u_host.wr(8'h29, tmo);
      u_host.rd(8'h2B, r);
      chk("power reg", r, {1'b1, pc & 8'h9F});
      chk("self test", 9'(self_test_en), 9'(pc[7]));
      u_host.rd(8'h29, r);
      chk("timeout reg", r, {1'b1, tmo});
    end
    for (int d = 0; d < 8; d++) begin
      rc = {2'(d), 3'(d), 2'($urandom), 1'b0};
      u_host.set_rate(rc);
      chk("data rate", 9'(output_sample_rate), 9'(d));
      chk("low noise", 9'(low_noise_sel), 9'(rc[2]));
      chk("fast read", 9'(fast_read), 9'(rc[1]));
    end
    for (int f = 0; f < 2; f++) begin
      u_host.set_rate({6'h00, 1'(f), 1'b0});
      u_host.req(4'h2, 8'h01, 8'h00);
      u_host.req(4'h1, 8'h00, 8'h00);
      chk("burst step", 9'(burst_addr), (f == 1) ? 9'h003 : 9'h002);
    end
    sleep_int_en = 1'b1;
    func_int_en = 4'hF;
    for (int i = 0; i < 3; i++) begin
      tmo = (i == 0) ? 8'h00 : 8'(1 + $urandom % 3);
      rc = {2'($urandom), (i == 2) ? 3'h7 : 3'($urandom % 7), 3'b001};
      pc = {3'b000, 2'($urandom), 1'b1, 2'($urandom)};
      u_host.wr(8'h29, tmo);
      u_host.wr(8'h2B, pc);
      u_host.set_rate(rc);
      wait_mode(1'b1, 200);
      chk("sleep delay", 9'(n), 9'(exp_delay(tmo, rc[5:3])));
      chk("sleep irq", 9'(sleep_transition_event), 9'h001);
      chk("sleep rate", 9'(output_sample_rate), {6'h00, 1'b1, rc[7:6]});
      chk("sleep os", 9'(oversample_sel), 9'(pc[4:3]));
      b = $urandom % 4;
      wake_sel = ~(4'h1 << b);
      pulse(4'h1 << b);
      chk("unselected", 9'(mode_sleep), 9'h001);
      wake_sel = 4'h1 << b;
      pulse(4'h1 << b);
      chk("wake irq", 9'({mode_sleep, sleep_transition_event}), 9'h001);
      chk("wake rate", 9'({output_sample_rate, oversample_sel}), 9'({rc[5:3], pc[1:0]}));
    end
    sleep_int_en = 1'b0;
    wake_sel = 4'h0;
    u_host.wr(8'h29, 8'h01);
    u_host.set_rate(8'h01);
    repeat (3) pulse(4'h8);
    chk("held awake", 9'(mode_sleep), 9'h000);
    wait_mode(1'b1, 50);
    chk("restart delay", 9'(n), 9'(FAST));
    chk("quiet sleep", 9'(sleep_transition_event), 9'h000);
    u_host.wr(8'h2B, 8'hFF);
    chk("soft reset", 9'({serial_if_reset, mode_active}), 9'h002);
    chk_defaults();
    u_host.set_rate(8'h01);
    wait_mode(1'b1, 64);
    chk("no auto sleep", 9'(mode_sleep), 9'h000);
    // Enable low must swallow a write and hold the mode
    ce = 1'b0;
    u_host.wr(8'h29, 8'h5A);
    ce = 1'b1;
    u_host.rd(8'h29, r);
    chk("frozen write", r, 9'h100);
    chk("frozen mode", 9'({mode_active, mode_sleep}), 9'h002);
    end_sim();
  end
endmodule
